// ---- core/uart_rx.sv ----
/*
  Receive half of the serial port: start-bit clock recovery with 16x or
  8x oversampling, three-sample majority data recovery, parity check,
  two-entry frame buffer with error flags, APB register access.
  Assumes a one-cycle oversampling tick from a baud generator on pclk
  and an asynchronous serial line that is synchronised here.
*/
`timescale 1ns/100ps
module uart_rx (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// serial line and baud tick
	input  wire logic        rxd,
	input  wire logic        sample_tick,
	// pin override and interrupt
	output logic             rx_pin_override,
	output logic             rx_irq
);
	typedef enum logic [1:0] {IDLE, START, DATA, STOP} rx_state_t;

	// line synchroniser
	logic       rxd_meta_reg;
	logic       rxd_sync_reg;
	logic       rxd_prev_reg;
	// registers
	logic [7:0] ctrl_b_reg;
	logic [7:0] ctrl_c_reg;
	logic       u2x_reg;
	logic       dor_pend_reg;
	// receive engine
	rx_state_t  state_reg;
	logic [3:0] smp_reg;
	logic [3:0] bit_reg;
	logic [2:0] vote_reg;
	logic [8:0] shift_reg;
	logic       par_reg;
	logic       hold_reg;
	logic [11:0] hold_data_reg;
	// outputs
	logic [31:0] prdata_reg;
	logic        pready_reg;
	logic        pslverr_reg;
	logic        override_reg;
	logic        irq_reg;

	function automatic logic maj3(input logic [2:0] s);
		maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction : maj3

	// configuration decode
	wire        rx_en    = ctrl_b_reg[uart_rx_pkg::RECEIVER_ENABLE_BIT];
	wire        par_en   = ctrl_c_reg[uart_rx_pkg::PEN_BIT];
	wire        par_odd  = ctrl_c_reg[uart_rx_pkg::PTYPE_BIT];
	wire [2:0]  char_sz  = {ctrl_b_reg[uart_rx_pkg::SZ2_BIT],
	                        ctrl_c_reg[uart_rx_pkg::SZ1_BIT],
	                        ctrl_c_reg[uart_rx_pkg::SZ0_BIT]};
	wire [3:0]  nbits    = (char_sz == 3'h7) ? 4'h9 :
	                       (char_sz > 3'h3) ? 4'h8 : 4'h5 + {2'b00, char_sz[1:0]};
	wire [3:0]  last_smp = u2x_reg ? uart_rx_pkg::SAMPLES_DOUBLE
	                               : uart_rx_pkg::SAMPLES_NORMAL;
	wire [3:0]  vote_lo  = u2x_reg ? uart_rx_pkg::VOTE_DOUBLE
	                               : uart_rx_pkg::VOTE_NORMAL;
	wire        in_vote  = (smp_reg >= vote_lo) && (smp_reg <= vote_lo + 4'h2);
	wire        vote_end = (smp_reg == vote_lo + 4'h2);
	wire        bit_end  = (smp_reg == last_smp);
	wire [2:0]  votes    = {vote_reg[1:0], rxd_sync_reg};
	wire        bit_val  = maj3(votes);
	wire        fall     = rxd_prev_reg && !rxd_sync_reg;

	// apb decode
	wire        apb_acc  = psel && penable;
	wire        apb_wr   = apb_acc && pwrite && pready_reg;
	wire        apb_rd   = apb_acc && !pwrite && pready_reg;
	wire        hit_st   = (paddr == uart_rx_pkg::STATUS_OFS);
	wire        hit_b    = (paddr == uart_rx_pkg::CTRL_B_OFS);
	wire        hit_c    = (paddr == uart_rx_pkg::CTRL_C_OFS);
	wire        hit_d    = (paddr == uart_rx_pkg::DATA_OFS);
	wire        hit_irq  = (paddr == uart_rx_pkg::IRQ_OFS);
	wire        mapped   = hit_st | hit_b | hit_c | hit_d | hit_irq;
	wire        pop      = apb_rd && hit_d;

	// buffer
	wire [11:0] head;
	wire        buf_ne;
	wire        buf_full;
	wire        flush    = !rx_en;
	wire        stop_done = (state_reg == STOP) && sample_tick && vote_end;
	wire        par_bad  = par_en && (par_reg ^ par_odd);
	// held frame moves to buffer whenever the buffer has room
	wire        push     = hold_reg && !buf_full;
	wire        new_start = (state_reg == START) && sample_tick && vote_end
	                        && !bit_val;
	wire        overrun  = new_start && hold_reg && buf_full;

	rx_frame_buffer #(
		.WIDTH (12),
		.DEPTH (uart_rx_pkg::BUF_DEPTH)
	) u_buf (
		.pclk      (pclk),
		.presetn   (presetn),
		.flush     (flush),
		.push      (push),
		.push_data (hold_data_reg),
		.pop       (pop),
		.head      (head),
		.not_empty (buf_ne),
		.full      (buf_full)
	);

	// head layout: {dor, fe, pe, ninth, data[7:0]}
	wire [7:0] st_rd;
	assign st_rd = {buf_ne, 2'b00, head[10] & buf_ne,
	                head[11] & buf_ne, head[9] & buf_ne,
	                u2x_reg, 1'b0};
	wire [7:0] b_rd = {ctrl_b_reg[7:2], head[8] & buf_ne, ctrl_b_reg[0]};
	wire [7:0] d_rd = buf_ne ? head[7:0] : 8'h00;
	wire [31:0] rd_mux = hit_st  ? {24'h000000, st_rd} :
	                     hit_b   ? {24'h000000, b_rd} :
	                     hit_c   ? {24'h000000, ctrl_c_reg} :
	                     hit_d   ? {24'h000000, d_rd} :
	                     hit_irq ? {31'h00000000, irq_reg} : 32'h00000000;

	// synchroniser: first stage read only by second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxd_meta_reg <= 1'b1;
			rxd_sync_reg <= 1'b1;
			rxd_prev_reg <= 1'b1;
		end else begin
			rxd_meta_reg <= rxd;
			rxd_sync_reg <= rxd_meta_reg;
			// previous sample, so an edge between ticks is not missed
			if (sample_tick)
				rxd_prev_reg <= rxd_sync_reg;
		end
	end

	// software registers; error flags are not writable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_b_reg <= uart_rx_pkg::CTRL_B_RST;
			ctrl_c_reg <= uart_rx_pkg::CTRL_C_RST;
			u2x_reg    <= uart_rx_pkg::U2X_RST;
		end else if (apb_wr) begin
			if (hit_b && pstrb[0])
				ctrl_b_reg <= {pwdata[7:2], 1'b0, pwdata[0]};
			if (hit_c && pstrb[0])
				ctrl_c_reg <= pwdata[7:0];
			if (hit_st && pstrb[0])
				u2x_reg <= pwdata[uart_rx_pkg::U2X_BIT];
		end
	end

	// receive engine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= IDLE;
			smp_reg   <= 4'h0;
			bit_reg   <= 4'h0;
			vote_reg  <= 3'h0;
			shift_reg <= 9'h000;
			par_reg   <= 1'b0;
		end else if (!rx_en) begin
			state_reg <= IDLE;
			smp_reg   <= 4'h0;
		end else if (sample_tick) begin
			if (in_vote)
				vote_reg <= votes;
			smp_reg <= bit_end ? 4'h0 : smp_reg + 4'h1;
			unique case (state_reg)
				IDLE: begin
					smp_reg <= 4'h1;
					if (fall || !rxd_sync_reg && rxd_prev_reg)
						state_reg <= START;
					else
						smp_reg <= 4'h0;
				end
				START: if (vote_end) begin
					if (bit_val) begin
						state_reg <= IDLE;
						smp_reg   <= 4'h0;
					end else begin
						bit_reg   <= 4'h0;
						par_reg   <= 1'b0;
						// short characters read zero in the upper bits
						shift_reg <= 9'h000;
					end
				end else if (bit_end) begin
					state_reg <= DATA;
				end
				DATA: if (vote_end) begin
					if (bit_reg < nbits)
						shift_reg[bit_reg] <= bit_val;
					par_reg <= par_reg ^ bit_val;
					bit_reg <= bit_reg + 4'h1;
				end else if (bit_end &&
				             bit_reg == nbits + {3'b000, par_en}) begin
					state_reg <= STOP;
				end
				STOP: if (vote_end) begin
					state_reg <= IDLE;
					smp_reg   <= 4'h0;
				end
			endcase
		end
	end

	// shift register hand-off into buffer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_reg      <= 1'b0;
			hold_data_reg <= 12'h000;
			dor_pend_reg  <= 1'b0;
		end else if (!rx_en) begin
			hold_reg     <= 1'b0;
			dor_pend_reg <= 1'b0;
		end else begin
			if (overrun)
				dor_pend_reg <= 1'b1;
			else if (push)
				dor_pend_reg <= 1'b0;
			if (stop_done && !hold_reg) begin
				hold_reg      <= 1'b1;
				hold_data_reg <= {dor_pend_reg | overrun,
				                  !bit_val,
				                  par_bad,
				                  shift_reg[8:0] & {(nbits == 4'h9),
				                                    8'hFF}};
			end else if (push) begin
				hold_reg <= 1'b0;
			end
			// the waiting frame carries the loss to the reader
			if (overrun)
				hold_data_reg[11] <= 1'b1;
		end
	end

	// bus outputs and interrupt; errors never feed the interrupt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg   <= 32'h00000000;
			pready_reg   <= 1'b0;
			pslverr_reg  <= 1'b0;
			override_reg <= 1'b0;
			irq_reg      <= 1'b0;
		end else begin
			pready_reg   <= psel && !pready_reg && !penable ? 1'b0 :
			                (apb_acc && !pready_reg);
			pslverr_reg  <= apb_acc && !pready_reg && !mapped;
			prdata_reg   <= (psel && !pwrite) ? rd_mux : 32'h00000000;
			override_reg <= rx_en;
			irq_reg      <= ctrl_b_reg[uart_rx_pkg::RECEIVE_INTERRUPT_ENABLE_BIT]
			                && buf_ne && !pop;
		end
	end

	assign prdata          = prdata_reg;
	assign pready          = pready_reg;
	assign pslverr         = pslverr_reg;
	assign rx_pin_override = override_reg;
	assign rx_irq          = irq_reg;
endmodule : uart_rx

// ---- core/uart_rx_pkg.sv ----
/*
  Shared constants for the serial receiver: APB register map, field
  positions, reset values and oversampling figures.
  Assumes a 32-bit APB bus with word-aligned registers.
*/
package uart_rx_pkg;
	// register byte addresses
	localparam logic [11:0] STATUS_OFS  = 12'h000;
	localparam logic [11:0] CTRL_B_OFS  = 12'h004;
	localparam logic [11:0] CTRL_C_OFS  = 12'h008;
	localparam logic [11:0] DATA_OFS    = 12'h00C;
	localparam logic [11:0] IRQ_OFS     = 12'h010;
	// status register fields
	localparam int PE_BIT   = 2;
	localparam int DOR_BIT  = 3;
	localparam int FE_BIT   = 4;
	localparam int U2X_BIT  = 1;
	localparam int RXC_BIT  = 7;
	// control b fields
	localparam int RECEIVED_NINTH_BIT_BIT  = 1;
	localparam int RECEIVER_ENABLE_BIT  = 4;
	localparam int RECEIVE_INTERRUPT_ENABLE_BIT = 7;
	localparam int SZ2_BIT   = 2;
	// control c fields
	localparam int SZ0_BIT   = 1;
	localparam int SZ1_BIT   = 2;
	localparam int STOP_BIT_COUNT_SELECT_BIT  = 3;
	localparam int PTYPE_BIT = 4;
	localparam int PEN_BIT   = 5;
	// reset values
	localparam logic [7:0] CTRL_B_RST = 8'h00;
	localparam logic [7:0] CTRL_C_RST = 8'h06;
	localparam logic       U2X_RST    = 1'b0;
	// oversampling and buffer depth
	localparam logic [3:0] SAMPLES_NORMAL = 4'hF;
	localparam logic [3:0] SAMPLES_DOUBLE = 4'h7;
	localparam logic [3:0] VOTE_NORMAL    = 4'h7;
	localparam logic [3:0] VOTE_DOUBLE    = 4'h3;
	localparam int         BUF_DEPTH      = 2;
endpackage : uart_rx_pkg

// ---- core/rx_frame_buffer.sv ----
/*
  Two-entry receive FIFO holding each frame with its ninth bit and
  error flags. Assumes push and pop come from the same clock domain.
*/
`timescale 1ns/100ps
module rx_frame_buffer #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// control
	input  wire logic             flush,
	// fill side
	input  wire logic             push,
	input  wire logic [WIDTH-1:0] push_data,
	// drain side
	input  wire logic             pop,
	output logic      [WIDTH-1:0] head,
	output logic                  not_empty,
	output logic                  full
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    rd_reg;
	logic [AW-1:0]    wr_reg;
	logic [AW:0]      cnt_reg;
	wire              do_push = push && !full;
	wire              do_pop  = pop && not_empty;

	function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
		inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : inc

	assign not_empty = (cnt_reg != '0);
	assign full      = (cnt_reg == (AW+1)'(DEPTH));
	assign head      = mem[rd_reg];

	always_ff @(posedge pclk) begin
		if (do_push)
			mem[wr_reg] <= push_data;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_reg  <= '0;
			wr_reg  <= '0;
			cnt_reg <= '0;
		end else if (flush) begin
			rd_reg  <= '0;
			wr_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			if (do_push)
				wr_reg <= inc(wr_reg);
			if (do_pop)
				rd_reg <= inc(rd_reg);
			cnt_reg <= cnt_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end
endmodule : rx_frame_buffer

// ---- verif/uart_rx_sva.sv ----
/*
  Port assertions for the serial receiver.
  Assumes it is bound to uart_rx and sees only that module's ports.
*/
`timescale 1ns/100ps
module uart_rx_sva (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// receiver outputs
	input wire logic        rx_pin_override,
	input wire logic        rx_irq
);
	wire acc     = psel && penable && pready;
	wire rd_data = acc && !pwrite && paddr == uart_rx_pkg::DATA_OFS;
	wire wr_ctrl = acc && pwrite && paddr == uart_rx_pkg::CTRL_B_OFS;
	wire rx_on   = pwdata[uart_rx_pkg::RECEIVER_ENABLE_BIT];
	wire mapped  = paddr <= uart_rx_pkg::IRQ_OFS && paddr[1:0] == 2'b00;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_wait; $rose(penable) && psel |=> pready; endproperty
	a_wait: assert property (p_wait) else $error("answer not after one wait");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("pready held too long");
	property p_err; pready |-> pslverr == !mapped; endproperty
	a_err: assert property (p_err) else $error("pslverr wrong for address");
	property p_on; wr_ctrl && rx_on |-> ##[1:2] rx_pin_override; endproperty
	a_on: assert property (p_on) else $error("pin not taken");
	property p_off; wr_ctrl && !rx_on |-> ##[1:2] !rx_pin_override; endproperty
	a_off: assert property (p_off) else $error("pin kept");
	property p_flush; !rx_pin_override [*3] |-> !rx_irq; endproperty
	a_flush: assert property (p_flush) else $error("irq while off");
	property p_fall;
		$fell(rx_irq) |-> $past(rd_data) || $past(rd_data, 2) ||
			$past(wr_ctrl) || $past(wr_ctrl, 2) || $past(wr_ctrl, 3);
	endproperty
	a_fall: assert property (p_fall) else $error("irq dropped alone");
	property p_pad; rd_data |-> prdata[31:8] == 24'h000000; endproperty
	a_pad: assert property (p_pad) else $error("data upper bits");
endmodule : uart_rx_sva
bind uart_rx uart_rx_sva i_uart_rx_sva (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_pin_override,
	.rx_irq);

// ---- verif/serial_tx_model.sv ----
/*
  Remote transmitter: drives the idle-high serial line and the tick.
  Assumes calls start just after a rising edge of pclk.
*/
`timescale 1ns/100ps
module serial_tx_model (
	// clock
	input  wire logic pclk,
	// line and tick
	output logic      rxd,
	output logic      sample_tick
);
	int tpb = 16;
	initial begin
		rxd = 1'b1;
		sample_tick = 1'b0;
	end
	always @(posedge pclk) sample_tick <= !sample_tick;
	task automatic hold(input logic v, input int n);
		rxd <= v;
		repeat (n) @(posedge pclk iff sample_tick);
	endtask : hold
	// lsb first, optional parity, one stop bit, then one idle bit
	task automatic send(input logic [7:0] d, input logic pen, par, stop);
		hold(1'b0, tpb);
		for (int i = 0; i < 8; i++) hold(d[i], tpb);
		if (pen) hold(par, tpb);
		hold(stop, tpb);
		hold(1'b1, tpb);
	endtask : send
endmodule : serial_tx_model

// ---- verif/uart_rx_tb.sv ----
/*
  Self-checking bench for uart_rx over APB with a transmitter model.
  Assumes the register map and fields of uart_rx_pkg.
*/
`timescale 1ns/100ps
module uart_rx_tb;
	localparam logic [11:0] ST = uart_rx_pkg::STATUS_OFS;
	localparam logic [11:0] CB = uart_rx_pkg::CTRL_B_OFS;
	localparam logic [11:0] CC = uart_rx_pkg::CTRL_C_OFS;
	localparam logic [11:0] DT = uart_rx_pkg::DATA_OFS;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        rxd, tick, ovr, irq;
	int          err_count = 0;
	int          checks = 0;
	uart_rx i_uart_rx (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr, .rxd,
		.sample_tick(tick), .rx_pin_override(ovr), .rx_irq(irq));
	serial_tx_model i_serial_tx_model (.pclk, .rxd, .sample_tick(tick));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	task automatic conclude;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, exp, input string m);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_count++;
			conclude();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rdc(input logic [11:0] a, input logic [31:0] e, string m);
		apb(1'b0, a, 32'h0);
		chk(rd, e, m);
	endtask : rdc
	task automatic test_regs;
		rdc(CC, 32'h06, "ctrl_c reset");
		rdc(CB, 32'h00, "ctrl_b reset");
		rdc(ST, 32'h00, "status reset");
		rdc(12'h020, 32'h0, "unmapped read");
		chk(er, 32'h1, "unmapped error");
		$display("test_regs done");
	endtask : test_regs
	task automatic test_basic;
		apb(1'b1, CB, 32'h90);
		repeat (2) @(posedge pclk);
		chk(ovr, 32'h1, "pin taken");
		i_serial_tx_model.send(8'hA5, 1'b0, 1'b0, 1'b1);
		chk(irq, 32'h1, "irq while done");
		rdc(ST, 32'h80, "done set");
		rdc(DT, 32'hA5, "data");
		rdc(ST, 32'h00, "done clear");
		chk(irq, 32'h0, "irq clear");
		$display("test_basic done");
	endtask : test_basic
	task automatic test_parity;
		logic        p;
		logic [31:0] e;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, CC, 32'h26 | (i[0] << 4) | (i[0] << 3));
			p = ^8'h3C ^ i[0] ^ i[1];
			i_serial_tx_model.send(8'h3C, 1'b1, p, i != 3);
			e = 32'h80 | (i[1] ? 32'h04 : 32'h0) | (i == 3 ? 32'h10 : 32'h0);
			rdc(ST, e, "parity and frame flags");
			apb(1'b1, ST, 32'h0);
			rdc(ST, e, "flags after write");
			rdc(DT, 32'h3C, "parity data");
		end
		$display("test_parity done");
	endtask : test_parity
	task automatic test_overrun;
		apb(1'b1, CC, 32'h06);
		for (int i = 0; i < 4; i++)
			i_serial_tx_model.send(8'h10 + i, 1'b0, 1'b0, 1'b1);
		for (int k = 0; k < 3; k++) begin
			rdc(ST, 32'h80 | (k == 2 ? 32'h08 : 32'h0), "overrun");
			rdc(DT, 32'h10 + k, "overrun data");
		end
		rdc(ST, 32'h00, "drained");
		i_serial_tx_model.send(8'h77, 1'b0, 1'b0, 1'b1);
		rdc(ST, 32'h80, "overrun cleared");
		rdc(DT, 32'h77, "after overrun");
		$display("test_overrun done");
	endtask : test_overrun
	task automatic test_disable;
		i_serial_tx_model.send(8'h55, 1'b0, 1'b0, 1'b1);
		fork
			i_serial_tx_model.send(8'h0F, 1'b0, 1'b0, 1'b1);
			begin
				repeat (100) @(posedge pclk);
				apb(1'b1, CB, 32'h80);
			end
		join
		chk(ovr, 32'h0, "pin released");
		chk(irq, 32'h0, "irq gone");
		apb(1'b1, CB, 32'h90);
		rdc(ST, 32'h00, "flushed");
		$display("test_disable done");
	endtask : test_disable
	task automatic test_double;
		apb(1'b1, ST, 32'h02);
		i_serial_tx_model.tpb = 8;
		i_serial_tx_model.hold(1'b0, 3);
		i_serial_tx_model.hold(1'b1, 20);
		rdc(ST, 32'h02, "spike rejected");
		i_serial_tx_model.send(8'hC3, 1'b0, 1'b0, 1'b1);
		rdc(ST, 32'h82, "double speed frame");
		rdc(DT, 32'hC3, "double speed data");
		$display("test_double done");
	endtask : test_double
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		test_regs();
		test_basic();
		test_parity();
		test_overrun();
		test_disable();
		test_double();
		conclude();
	end
endmodule : uart_rx_tb
